// >>> rtl/pie_bank.v
// Chosen here: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "pie_defs.vh"
module pie_bank (
  input wire sys_clk,
  input wire sys_rst,
  input wire clk_en,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire capcomp5_flag,
  input wire capcomp4_flag,
  input wire capcomp3_flag,
  input wire timer6_match_flag,
  input wire timer4_match_flag,
  output reg [7:0] periph_irq_req,
  output reg periph_irq,
  output reg irq
);
  // ----------------------------------------------------------------
  // flag synchronisers
  // ----------------------------------------------------------------
  // flags come from other logic possibly on other clocks, so sync them
  wire [7:0] flags_raw;
  wire [7:0] flags_s;

  assign flags_raw = {1'b0, capcomp5_flag, capcomp4_flag, capcomp3_flag,
                      timer6_match_flag, 1'b0, timer4_match_flag, 1'b0};

  pie_sync #(.WIDTH(8)) u_sync (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .async_in(flags_raw),
    .sync_out(flags_s)
  );

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg [7:0] peripheral_irq_enable_second_q;
  reg periph_gate_q;
  reg [7:0] irq_stat_q;
  reg [7:0] irq_en_q;
  reg [7:0] req_prev_q;

  wire [7:0] req_raw;
  wire [7:0] req_rise;
  wire wr_acc;
  wire wr_lo;

  // single-cycle access phase: ready answers in the first penable cycle
  assign wr_acc = psel & penable & pwrite & clk_en;
  assign wr_lo = wr_acc & pstrb[0];

  function is_mapped;
    input [11:0] a;
    begin
      is_mapped = (a == `PIE_OFF_ENABLE) || (a == `PIE_OFF_FLAGS) ||
                  (a == `PIE_OFF_REQ) || (a == `PIE_OFF_GATE) ||
                  (a == `PIE_OFF_IRQ_STAT) || (a == `PIE_OFF_IRQ_CLR) ||
                  (a == `PIE_OFF_IRQ_EN);
    end
  endfunction

  // ----------------------------------------------------------------
  // request gating
  // ----------------------------------------------------------------
  // per-bit and; unimplemented positions are masked out
  assign req_raw[`PIE_BIT_CCP5] = flags_s[`PIE_BIT_CCP5] &
                                  peripheral_irq_enable_second_q[`PIE_BIT_CCP5];
  assign req_raw[`PIE_BIT_CCP4] = flags_s[`PIE_BIT_CCP4] &
                                  peripheral_irq_enable_second_q[`PIE_BIT_CCP4];
  assign req_raw[`PIE_BIT_CCP3] = flags_s[`PIE_BIT_CCP3] &
                                  peripheral_irq_enable_second_q[`PIE_BIT_CCP3];
  assign req_raw[`PIE_BIT_TMR6] = flags_s[`PIE_BIT_TMR6] &
                                  peripheral_irq_enable_second_q[`PIE_BIT_TMR6];
  assign req_raw[`PIE_BIT_TMR4] = flags_s[`PIE_BIT_TMR4] &
                                  peripheral_irq_enable_second_q[`PIE_BIT_TMR4];
  assign req_raw[7] = 1'b0;
  assign req_raw[2] = 1'b0;
  assign req_raw[0] = 1'b0;
  assign req_rise = req_raw & ~req_prev_q;

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      peripheral_irq_enable_second_q <= `PIE_ENABLE_RST;
      periph_gate_q <= `PIE_GATE_RST;
      irq_en_q <= `PIE_IRQ_EN_RST;
      irq_stat_q <= 8'h00;
      req_prev_q <= 8'h00;
      periph_irq_req <= 8'h00;
      periph_irq <= 1'b0;
      irq <= 1'b0;
    end else if (clk_en) begin
      req_prev_q <= req_raw;
      if (wr_lo && paddr == `PIE_OFF_ENABLE) begin
        peripheral_irq_enable_second_q <= pwdata[7:0] & `PIE_IMPL_MASK;
      end
      if (wr_lo && paddr == `PIE_OFF_GATE) begin
        periph_gate_q <= pwdata[0];
      end
      if (wr_lo && paddr == `PIE_OFF_IRQ_EN) begin
        irq_en_q <= pwdata[7:0] & `PIE_IMPL_MASK;
      end
      // new rising request wins over a same-cycle clear
      if (wr_lo && paddr == `PIE_OFF_IRQ_CLR) begin
        irq_stat_q <= (irq_stat_q & ~pwdata[7:0]) | req_rise;
      end else begin
        irq_stat_q <= irq_stat_q | req_rise;
      end
      periph_irq_req <= req_raw;
      periph_irq <= periph_gate_q & (|req_raw);
      irq <= |(irq_stat_q & irq_en_q);
    end
  end

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready <= psel & ~penable & ~pready;
      pslverr <= psel & ~penable & ~pready & ~is_mapped(paddr);
      prdata <= 32'h00000000;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          `PIE_OFF_ENABLE: begin
            prdata <= {24'h000000, peripheral_irq_enable_second_q & `PIE_IMPL_MASK};
          end
          `PIE_OFF_FLAGS: begin
            prdata <= {24'h000000, flags_s & `PIE_IMPL_MASK};
          end
          `PIE_OFF_REQ: begin
            prdata <= {24'h000000, req_raw};
          end
          `PIE_OFF_GATE: begin
            prdata <= {31'h00000000, periph_gate_q};
          end
          `PIE_OFF_IRQ_STAT: begin
            prdata <= {24'h000000, irq_stat_q};
          end
          `PIE_OFF_IRQ_EN: begin
            prdata <= {24'h000000, irq_en_q};
          end
          default: begin
            prdata <= 32'h00000000;
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// >>> rtl/pie_defs.vh
`ifndef PIE_DEFS_VH
`define PIE_DEFS_VH

// apb byte offsets
`define PIE_OFF_ENABLE 12'h000
`define PIE_OFF_FLAGS 12'h004
`define PIE_OFF_REQ 12'h008
`define PIE_OFF_GATE 12'h00C
`define PIE_OFF_IRQ_STAT 12'h010
`define PIE_OFF_IRQ_CLR 12'h014
`define PIE_OFF_IRQ_EN 12'h018

// enable register field positions
`define PIE_BIT_CCP5 6
`define PIE_BIT_CCP4 5
`define PIE_BIT_CCP3 4
`define PIE_BIT_TMR6 3
`define PIE_BIT_TMR4 1

// implemented bits: 6,5,4,3,1; bits 7,2,0 read zero
`define PIE_IMPL_MASK 8'h7A
`define PIE_ENABLE_RST 8'h00
`define PIE_GATE_RST 1'b0
`define PIE_IRQ_EN_RST 8'h00

`endif

// >>> rtl/pie_sync.v
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser for asynchronous source flags
module pie_sync #(
  parameter WIDTH = 8
) (
  input wire sys_clk,
  input wire sys_rst,
  input wire clk_en,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_q;

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      meta_q <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else if (clk_en) begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule
`default_nettype wire

// >>> bench/pie_bank_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module pie_chk (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic capcomp5_flag,
  input wire logic capcomp4_flag,
  input wire logic capcomp3_flag,
  input wire logic timer6_match_flag,
  input wire logic timer4_match_flag,
  input wire logic [7:0] periph_irq_req,
  input wire logic periph_irq
);
  // a frozen clock enable stalls the flag pipe, so the delays below only hold while it runs
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst || !clk_en);
  AST_ANSWER: assert property (psel && !penable && !pready |=> pready ##1 !pready)
    else $error("no single answer");
  AST_REQ_ZERO: assert property ((periph_irq_req & 8'h85) == 8'h00)
    else $error("unused request bit set");
  AST_CC5: assert property (periph_irq_req[6] |-> $past(capcomp5_flag, 3))
    else $error("cc5 request without flag");
  AST_CC4: assert property (periph_irq_req[5] |-> $past(capcomp4_flag, 3))
    else $error("cc4 request without flag");
  AST_CC3: assert property (periph_irq_req[4] |-> $past(capcomp3_flag, 3))
    else $error("cc3 request without flag");
  AST_T6: assert property (periph_irq_req[3] |-> $past(timer6_match_flag, 3))
    else $error("timer6 request without flag");
  AST_T4: assert property (periph_irq_req[1] |-> $past(timer4_match_flag, 3))
    else $error("timer4 request without flag");
  AST_PIRQ: assert property (periph_irq |-> (|periph_irq_req) || $past(|periph_irq_req))
    else $error("irq without request");
endmodule
bind pie_bank pie_chk u_chk (.*);
`default_nettype wire

// >>> bench/peripheral_irq_enable_bank_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "pie_defs.vh"
module peripheral_irq_enable_bank_bench;
  logic sys_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, periph_irq, irq, err, ce = 1;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, v, seed = 32'h6CA2DE12;
  logic [7:0] f = 0, en, q0 = 0, q1, q2, st = 0, periph_irq_req;
  int n_fail = 0, checks = 0;
  always #2.5 sys_clk = ~sys_clk;
  pie_bank DUT (.sys_clk, .sys_rst, .clk_en(ce), .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hF),
    .prdata, .pready, .pslverr, .capcomp5_flag(f[6]), .capcomp4_flag(f[5]), .capcomp3_flag(f[4]),
    .timer6_match_flag(f[3]), .timer4_match_flag(f[1]), .periph_irq_req, .periph_irq, .irq);
  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      n_fail++;
      $display("BAD %0t got %h want %h", $time, s, e);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task close_out;
    $display("fails %0d checks %0d", n_fail, checks);
    if (n_fail == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #100000;
    n_fail++;
    close_out;
  end
  initial begin
    repeat (20) @(posedge sys_clk);
    sys_rst <= 0;
    apb(0, `PIE_OFF_ENABLE, 0);
    chk(rd, 0);
    apb(1, `PIE_OFF_GATE, 1);
    for (int i = 0; i < 16; i++) begin
      v = xs();
      apb(1, `PIE_OFF_ENABLE, v);
      en = v[7:0] & 8'h7A;
      q1 = f & en;
      q2 = v[15:8] & en;
      f <= v[15:8] & 8'h7A;
      apb(1, `PIE_OFF_IRQ_EN, v[23:16]);
      apb(0, `PIE_OFF_ENABLE, 0);
      chk(rd, {24'h0, en});
      repeat (4) @(posedge sys_clk);
      // status catches the rise at either step, enable first, then flags
      st = st | q1 & ~q0 | q2 & ~q1;
      q0 = q2;
      chk(periph_irq_req, q2);
      chk(periph_irq, |q2);
      chk(irq, |(st & v[23:16]));
      apb(0, `PIE_OFF_IRQ_STAT, 0);
      chk(rd, st);
      apb(1, `PIE_OFF_IRQ_CLR, 32'hFF);
      st = 0;
    end
    // frozen enable must hold the request outputs while the flags move
    ce <= 0;
    f <= v[31:24] & 8'h7A;
    repeat (5) @(posedge sys_clk);
    chk(periph_irq_req, q2);
    ce <= 1;
    repeat (4) @(posedge sys_clk);
    chk(periph_irq_req, v[31:24] & en);
    apb(0, 12'h040, 0);
    chk(err, 1);
    chk(rd, 0);
    sys_rst <= 1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 0;
    f <= 0;
    apb(0, `PIE_OFF_ENABLE, 0);
    chk(rd, 0);
    close_out;
  end
endmodule
`default_nettype wire
